// *** src/thermal_sensor_config_regs.sv ***
/*
 * Capability report and sensor configuration register of a temperature
 * sensor, reached over a two-wire serial slave through a register pointer,
 * together with the event output logic steered by the configuration.
 * Assumes the limit comparisons are done outside on the same clock and
 * arrive as trip levels, and that the pins are open-drain with pull-ups.
 */
`timescale 1ns/10ps
`include "thermal_sensor_params.svh"
module thermal_sensor_config_regs
   import thermal_cfg_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h18,
   parameter int SUB_ZERO_SUPPORT = 1,
   parameter int ACCURACY_TIGHT = 1
)
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic [1:0] resolution_i,
   input wire logic crit_trip_i,
   input wire logic upper_trip_i,
   input wire logic lower_trip_i,
   output logic event_o,
   output logic low_power_select_o,
   output logic [1:0] limit_hysteresis_o,
   output logic crit_lock_o,
   output logic win_lock_o
);
   // The device address is arbitrary; the DEV_ADDR parameter picks the real one.
   if (SUB_ZERO_SUPPORT < 0 || SUB_ZERO_SUPPORT > 1) begin : g_bad_range
      $error("SUB_ZERO_SUPPORT must be 0 or 1");
   end
   if (ACCURACY_TIGHT < 0 || ACCURACY_TIGHT > 1) begin : g_bad_acc
      $error("ACCURACY_TIGHT must be 0 or 1");
   end

   localparam logic SUB_ZERO_BIT = SUB_ZERO_SUPPORT[0];
   localparam logic ACCURACY_BIT = ACCURACY_TIGHT[0];

   line_events_if ev ();

   line_sampler u_sampler (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .ev(ev.source)
   );

   core_s q;
   core_s next_q;

   logic any_lock;
   logic event_cond;
   logic event_active;
   logic [15:0] wr_word;

   // Builds the capability word from live resolution and fixed grades.
   function automatic logic [15:0] capability_word(input logic [1:0] res);
      logic [15:0] w;
      w = '0;
      w[`CAP_RES_HI:`CAP_RES_LO] = res;
      w[`CAP_RANGE] = SUB_ZERO_BIT;
      w[`CAP_ACCURACY] = ACCURACY_BIT;
      w[`CAP_ALARM] = 1'b1;
      return w;
   endfunction : capability_word

   // Builds the configuration read word; unused bits stay zero.
   function automatic logic [15:0] config_word(input sensor_cfg_s c, input logic stat);
      logic [15:0] w;
      w = `CFG_RESET;
      w[`CFG_HYST_HI:`CFG_HYST_LO] = c.limit_hysteresis;
      w[`CFG_LOW_POWER] = c.low_power_select;
      w[`CFG_CRIT_LOCK] = c.crit_lock;
      w[`CFG_WIN_LOCK] = c.win_lock;
      w[`CFG_INT_CLEAR] = 1'b0;
      w[`CFG_EVT_STATUS] = stat;
      w[`CFG_EVT_ENABLE] = c.evt_enable;
      w[`CFG_EVT_SELECT] = c.evt_select;
      w[`CFG_EVT_POLARITY] = c.evt_polarity;
      w[`CFG_EVT_MODE] = c.evt_mode;
      return w;
   endfunction : config_word

   // Unpacks a configuration word into the stored fields; status and clear are not kept.
   function automatic sensor_cfg_s config_fields(input logic [15:0] w);
      sensor_cfg_s c;
      c.limit_hysteresis = w[`CFG_HYST_HI:`CFG_HYST_LO];
      c.low_power_select = w[`CFG_LOW_POWER];
      c.crit_lock = w[`CFG_CRIT_LOCK];
      c.win_lock = w[`CFG_WIN_LOCK];
      c.evt_enable = w[`CFG_EVT_ENABLE];
      c.evt_select = w[`CFG_EVT_SELECT];
      c.evt_polarity = w[`CFG_EVT_POLARITY];
      c.evt_mode = w[`CFG_EVT_MODE];
      return c;
   endfunction : config_fields

   // Selects the word a read returns; unmapped pointers read zero here.
   function automatic logic [15:0] read_word(input logic [3:0] ptr, input sensor_cfg_s c,
                                             input logic stat, input logic [1:0] res);
      logic [15:0] w;
      w = '0;
      if (ptr == `PTR_CAPABILITY) begin
         w = capability_word(res);
      end else if (ptr == `PTR_SENSOR_CONFIG) begin
         w = config_word(c, stat);
      end
      return w;
   endfunction : read_word

   assign any_lock = q.cfg.crit_lock | q.cfg.win_lock;
   // Critical-only selection drops the window trips from the event.
   assign event_cond = q.cfg.evt_select ? crit_trip_i
                                        : (crit_trip_i | upper_trip_i | lower_trip_i);
   // In interrupt mode a critical trip still drives the output as a level.
   assign event_active = q.cfg.evt_enable &
                         (q.cfg.evt_mode ? (q.int_pend | crit_trip_i) : event_cond);
   assign wr_word = {q.wr_msb, q.shift};

   always_comb begin
      next_q = q;
      next_q.prev_cond = event_cond;
      // Interrupt latch: a new event in the clearing cycle wins over the clear.
      if (q.st == LINK_WR_DATA && ev.scl_fall && q.bit_cnt == `BYTE_BITS && q.byte_sel
          && q.pointer == `PTR_SENSOR_CONFIG && wr_word[`CFG_INT_CLEAR]) begin
         next_q.int_pend = 1'b0;
      end
      if (q.cfg.evt_mode && event_cond && !q.prev_cond) begin
         next_q.int_pend = 1'b1;
      end
      next_q.event_pin = q.cfg.evt_polarity ? event_active : ~event_active;

      if (ev.scl_rise) begin
         if (q.st == LINK_ADDR || q.st == LINK_PTR || q.st == LINK_WR_DATA) begin
            next_q.shift = {q.shift[6:0], ev.sda_level};
            next_q.bit_cnt = q.bit_cnt + 4'h1;
         end else if (q.st == LINK_RD_DATA) begin
            next_q.bit_cnt = q.bit_cnt + 4'h1;
         end else if (q.st == LINK_RD_ACK) begin
            next_q.rd_nack = ev.sda_level;
         end
      end

      if (ev.scl_fall) begin
         case (q.st)
            LINK_ADDR: begin
               if (q.bit_cnt == `BYTE_BITS) begin
                  if (q.shift[7:1] == DEV_ADDR) begin
                     next_q.is_read = q.shift[0];
                     next_q.sda_drive = 1'b1;
                     next_q.st = LINK_ADDR_ACK;
                  end else begin
                     next_q.st = LINK_IDLE;
                  end
               end
            end
            LINK_ADDR_ACK: begin
               next_q.bit_cnt = '0;
               next_q.byte_sel = 1'b0;
               if (q.is_read) begin
                  // Reads work in shutdown too: nothing here looks at low power.
                  next_q.tx = read_word(q.pointer, q.cfg, event_active, resolution_i);
                  next_q.sda_drive = ~next_q.tx[15];
                  next_q.st = LINK_RD_DATA;
               end else begin
                  next_q.sda_drive = 1'b0;
                  next_q.st = LINK_PTR;
               end
            end
            LINK_PTR: begin
               if (q.bit_cnt == `BYTE_BITS) begin
                  next_q.pointer = q.shift[`PTR_WIDTH-1:0];
                  next_q.sda_drive = 1'b1;
                  next_q.st = LINK_PTR_ACK;
               end
            end
            LINK_PTR_ACK: begin
               next_q.sda_drive = 1'b0;
               next_q.bit_cnt = '0;
               next_q.byte_sel = 1'b0;
               next_q.st = LINK_WR_DATA;
            end
            LINK_WR_DATA: begin
               if (q.bit_cnt == `BYTE_BITS) begin
                  // Every data byte is acknowledged, locked or not.
                  next_q.sda_drive = 1'b1;
                  next_q.st = LINK_WR_ACK;
                  if (!q.byte_sel) begin
                     next_q.wr_msb = q.shift;
                  end else if (q.pointer == `PTR_SENSOR_CONFIG) begin
                     if (!any_lock) begin
                        next_q.cfg.limit_hysteresis = wr_word[`CFG_HYST_HI:`CFG_HYST_LO];
                        next_q.cfg.evt_enable = wr_word[`CFG_EVT_ENABLE];
                        next_q.cfg.evt_polarity = wr_word[`CFG_EVT_POLARITY];
                        next_q.cfg.evt_mode = wr_word[`CFG_EVT_MODE];
                     end
                     if (!q.cfg.win_lock) begin
                        next_q.cfg.evt_select = wr_word[`CFG_EVT_SELECT];
                     end
                     if (!wr_word[`CFG_LOW_POWER]) begin
                        next_q.cfg.low_power_select = 1'b0;
                     end else if (!any_lock) begin
                        next_q.cfg.low_power_select = 1'b1;
                     end
                     // Locks only ever set; the reset alone releases them.
                     next_q.cfg.crit_lock = q.cfg.crit_lock | wr_word[`CFG_CRIT_LOCK];
                     next_q.cfg.win_lock = q.cfg.win_lock | wr_word[`CFG_WIN_LOCK];
                  end
               end
            end
            LINK_WR_ACK: begin
               next_q.sda_drive = 1'b0;
               next_q.bit_cnt = '0;
               next_q.byte_sel = ~q.byte_sel;
               next_q.st = LINK_WR_DATA;
            end
            LINK_RD_DATA: begin
               if (q.bit_cnt == `BYTE_BITS) begin
                  next_q.sda_drive = 1'b0;
                  next_q.st = LINK_RD_ACK;
               end else begin
                  next_q.tx = {q.tx[14:0], 1'b0};
                  next_q.sda_drive = ~q.tx[14];
               end
            end
            LINK_RD_ACK: begin
               if (q.rd_nack) begin
                  next_q.st = LINK_IDLE;
               end else begin
                  next_q.bit_cnt = '0;
                  next_q.byte_sel = ~q.byte_sel;
                  // After the low byte the word is fetched again, so a long
                  // read repeats the register rather than walking the map.
                  if (q.byte_sel) begin
                     next_q.tx = read_word(q.pointer, q.cfg, event_active, resolution_i);
                  end else begin
                     next_q.tx = {q.tx[14:0], 1'b0};
                  end
                  next_q.sda_drive = ~next_q.tx[15];
                  next_q.st = LINK_RD_DATA;
               end
            end
            default: begin
               next_q.sda_drive = 1'b0;
            end
         endcase
      end

      if (ev.start_seen) begin
         next_q.st = LINK_ADDR;
         next_q.bit_cnt = '0;
         next_q.sda_drive = 1'b0;
      end else if (ev.stop_seen) begin
         next_q.st = LINK_IDLE;
         next_q.sda_drive = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         q <= '0;
         q.st <= LINK_IDLE;
         q.cfg <= config_fields(`CFG_RESET);
         q.event_pin <= `EVT_PIN_RESET;
      end else begin
         q <= next_q;
      end
   end

   // Open-drain data: the pin is only ever pulled low.
   assign sda_o = 1'b0;
   assign sda_oe_o = q.sda_drive;
   assign event_o = q.event_pin;
   assign low_power_select_o = q.cfg.low_power_select;
   assign limit_hysteresis_o = q.cfg.limit_hysteresis;
   assign crit_lock_o = q.cfg.crit_lock;
   assign win_lock_o = q.cfg.win_lock;
endmodule : thermal_sensor_config_regs

// *** src/thermal_sensor_params.svh ***
/*
 * Constants for the sensor configuration register block: register pointers,
 * field positions, reset values and serial framing counts.
 * Assumes it is included by bare name from each design file that needs it.
 */
`ifndef THERMAL_SENSOR_PARAMS_SVH
`define THERMAL_SENSOR_PARAMS_SVH

`define PTR_WIDTH 4
`define PTR_CAPABILITY 4'h0
`define PTR_SENSOR_CONFIG 4'h1

`define CFG_HYST_HI 10
`define CFG_HYST_LO 9
`define CFG_LOW_POWER 8
`define CFG_CRIT_LOCK 7
`define CFG_WIN_LOCK 6
`define CFG_INT_CLEAR 5
`define CFG_EVT_STATUS 4
`define CFG_EVT_ENABLE 3
`define CFG_EVT_SELECT 2
`define CFG_EVT_POLARITY 1
`define CFG_EVT_MODE 0
`define CFG_RESET 16'h0000

`define CAP_RES_HI 4
`define CAP_RES_LO 3
`define CAP_RANGE 2
`define CAP_ACCURACY 1
`define CAP_ALARM 0

`define BYTE_BITS 4'h8
`define EVT_PIN_RESET 1'b1

`endif

// *** src/thermal_cfg_pkg.sv ***
/*
 * Types shared by the sensor configuration block and its line sampler.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package thermal_cfg_pkg;

   typedef enum logic [3:0] {
      LINK_IDLE,
      LINK_ADDR,
      LINK_ADDR_ACK,
      LINK_PTR,
      LINK_PTR_ACK,
      LINK_WR_DATA,
      LINK_WR_ACK,
      LINK_RD_DATA,
      LINK_RD_ACK
   } link_state_e;

   typedef struct packed {
      logic [1:0] limit_hysteresis;
      logic low_power_select;
      logic crit_lock;
      logic win_lock;
      logic evt_enable;
      logic evt_select;
      logic evt_polarity;
      logic evt_mode;
   } sensor_cfg_s;

   typedef struct packed {
      link_state_e st;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic [15:0] tx;
      logic [7:0] wr_msb;
      logic byte_sel;
      logic rd_nack;
      logic is_read;
      logic [3:0] pointer;
      logic sda_drive;
      sensor_cfg_s cfg;
      logic int_pend;
      logic prev_cond;
      logic event_pin;
   } core_s;

   typedef struct packed {
      logic [1:0] scl_sync;
      logic [1:0] sda_sync;
      logic scl_d;
      logic sda_d;
   } sampler_s;

endpackage : thermal_cfg_pkg

// *** src/line_events_if.sv ***
/*
 * Carrier for the sampled two-wire line events between the sampler and
 * the register block. Assumes both ends run on the same system clock.
 */
`timescale 1ns/10ps
interface line_events_if;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic sda_level;

   modport source (
      output scl_rise,
      output scl_fall,
      output start_seen,
      output stop_seen,
      output sda_level
   );
   modport sink (
      input scl_rise,
      input scl_fall,
      input start_seen,
      input stop_seen,
      input sda_level
   );
endinterface : line_events_if

// *** src/line_sampler.sv ***
/*
 * Synchronises the serial clock and data pins to the system clock and
 * reports the serial clock edges and start and stop conditions as one-cycle pulses.
 * Assumes the serial clock is much slower than the system clock.
 */
`timescale 1ns/10ps
module line_sampler
   import thermal_cfg_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   line_events_if.source ev
);
   sampler_s q;
   sampler_s next_q;

   always_comb begin
      next_q = q;
      next_q.scl_sync = {q.scl_sync[0], scl_i};
      next_q.sda_sync = {q.sda_sync[0], sda_i};
      next_q.scl_d = q.scl_sync[1];
      next_q.sda_d = q.sda_sync[1];
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         q <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl_d: 1'b1, sda_d: 1'b1};
      end else begin
         q <= next_q;
      end
   end

   // Only the second synchroniser stage and its delayed copy feed the edges.
   assign ev.scl_rise = q.scl_sync[1] & ~q.scl_d;
   assign ev.scl_fall = ~q.scl_sync[1] & q.scl_d;
   assign ev.start_seen = q.scl_sync[1] & q.scl_d & q.sda_d & ~q.sda_sync[1];
   assign ev.stop_seen = q.scl_sync[1] & q.scl_d & ~q.sda_d & q.sda_sync[1];
   assign ev.sda_level = q.sda_sync[1];
endmodule : line_sampler

// *** tb/cfg_host_model.sv ***
/* Behavioural host on the two-wire serial bus: start, stop, byte writes and reads.
   Assumes an open-drain data line with a pull-up and the block's device address. */
`timescale 1ns/10ps
module cfg_host_model #(
   parameter logic [6:0] ADDR = 7'h18
)
(
   input wire logic clk_i,
   input wire logic sda_oe_i,
   output logic scl_o,
   output logic line_o
);
   logic sda_q = 1'b1;
   int nack_cnt = 0;
   initial scl_o = 1'b1;
   // A released line floats to the pull-up level unless the device pulls it.
   assign line_o = sda_q & ~sda_oe_i;

   // Data moves one clock after the fall, long before the device's answer lag ends.
   task automatic bitx(input logic b, output logic r);
      @(posedge clk_i) sda_q <= b;
      repeat (4) @(posedge clk_i);
      scl_o <= 1'b1;
      @(negedge clk_i) r = line_o;
      repeat (3) @(posedge clk_i);
      scl_o <= 1'b0;
   endtask : bitx

   task automatic xbyte(input logic [7:0] d, input logic rd, input logic ak,
                        output logic [7:0] q);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], q[i]);
      end
      bitx(rd ? ak : 1'b1, a);
      if (!rd && a !== 1'b0) begin
         nack_cnt++;
      end
   endtask : xbyte

   task automatic start;
      @(posedge clk_i) sda_q <= 1'b0;
      repeat (4) @(posedge clk_i);
      scl_o <= 1'b0;
   endtask : start

   task automatic stop;
      @(posedge clk_i) sda_q <= 1'b0;
      repeat (4) @(posedge clk_i);
      scl_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sda_q <= 1'b1;
      repeat (4) @(posedge clk_i);
   endtask : stop

   task automatic wr(input logic [3:0] p, input logic [15:0] v);
      logic [7:0] q;
      start();
      xbyte({ADDR, 1'b0}, 1'b0, 1'b0, q);
      xbyte({4'h0, p}, 1'b0, 1'b0, q);
      xbyte(v[15:8], 1'b0, 1'b0, q);
      xbyte(v[7:0], 1'b0, 1'b0, q);
      stop();
   endtask : wr

   task automatic rd(input logic [3:0] p, output logic [15:0] v);
      logic [7:0] q;
      start();
      xbyte({ADDR, 1'b0}, 1'b0, 1'b0, q);
      xbyte({4'h0, p}, 1'b0, 1'b0, q);
      stop();
      start();
      xbyte({ADDR, 1'b1}, 1'b0, 1'b0, q);
      xbyte(8'hff, 1'b1, 1'b0, v[15:8]);
      xbyte(8'hff, 1'b1, 1'b1, v[7:0]);
      stop();
   endtask : rd
endmodule : cfg_host_model

// *** tb/thermal_sensor_config_regs_chk.sv ***
/* Port checker for the configuration register block, bound below.
   Assumes one clock domain with a synchronous active-low reset. */
`timescale 1ns/10ps
module thermal_sensor_config_regs_chk (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic crit_trip_i,
   input wire logic upper_trip_i,
   input wire logic lower_trip_i,
   input wire logic event_o,
   input wire logic low_power_select_o,
   input wire logic [1:0] limit_hysteresis_o,
   input wire logic crit_lock_o,
   input wire logic win_lock_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [3:0] cur;
   logic [3:0] prev_in;
   logic [3:0] quiet;
   logic [3:0] since_fall;
   logic [7:0] oe_run;
   logic scl_d;
   logic lk;
   assign lk = crit_lock_o | win_lock_o;
   assign cur = {scl_i, crit_trip_i, upper_trip_i, lower_trip_i};
   // The quiet and since_fall counters saturate so that a long idle spell never wraps below 8 and masks a failure.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         prev_in <= 4'h0;
         quiet <= 4'h0;
         since_fall <= 4'hf;
         oe_run <= 8'h00;
         scl_d <= 1'b1;
      end else begin
         prev_in <= cur;
         quiet <= (prev_in != cur) ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
         scl_d <= scl_i;
         since_fall <= (scl_d & ~scl_i) ? 4'h0 : since_fall + {3'h0, since_fall != 4'hf};
         oe_run <= sda_oe_o ? oe_run + 8'h01 : 8'h00;
      end
   end
   a_crit_lock_sticky: assert property (crit_lock_o |=> crit_lock_o)
      else $error("critical lock dropped without reset");
   a_win_lock_sticky: assert property (win_lock_o |=> win_lock_o)
      else $error("window lock dropped without reset");
   a_hyst_when_locked: assert property (lk |=> $stable(limit_hysteresis_o))
      else $error("hysteresis changed while locked");
   a_low_power_select_set_locked: assert property (lk && !low_power_select_o |=> !low_power_select_o)
      else $error("shutdown set while locked");
   // A configuration write may move the pin with quiet inputs, so bus activity excuses it.
   a_event_quiet_in: assert property (quiet >= 4'h8 && since_fall >= 4'h8 |-> $stable(event_o))
      else $error("event pin moved with no cause");
   a_cfg_after_fall: assert property ($changed({limit_hysteresis_o, low_power_select_o,
      crit_lock_o, win_lock_o}) |-> since_fall <= 4'h7)
      else $error("configuration changed away from a bus write");
   a_oe_run_bounded: assert property (oe_run < 8'h50)
      else $error("data line held low too long");
   a_data_open_drain: assert property (sda_o == 1'b0)
      else $error("data output not open drain");
   cover property ($rose(crit_lock_o));
   cover property ($fell(event_o));
   cover property (lk && $fell(low_power_select_o));
endmodule : thermal_sensor_config_regs_chk

bind thermal_sensor_config_regs thermal_sensor_config_regs_chk thermal_sensor_config_regs_chk_i (
   .sys_clk_i, .rst_n_i, .scl_i, .sda_o, .sda_oe_o, .crit_trip_i, .upper_trip_i,
   .lower_trip_i, .event_o, .low_power_select_o, .limit_hysteresis_o, .crit_lock_o,
   .win_lock_o);

// *** tb/thermal_sensor_config_regs_tb.sv ***
/* Self-checking bench for the configuration register block: the host model
   drives the serial bus, the bench drives resolution and trip levels.
   Assumes the block's default device address. */
`timescale 1ns/10ps
module thermal_sensor_config_regs_tb;
   logic clk;
   logic rst_n;
   logic scl;
   logic sda;
   logic oe;
   logic [1:0] res;
   logic crit, upper, lower;
   logic ev, lp, cl, wl;
   logic [1:0] hy;
   logic [15:0] v;
   int error_cnt = 0;
   int n_checks = 0;
   int cyc = 0;

   thermal_sensor_config_regs thermal_sensor_config_regs_i (
      .sys_clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(),
      .sda_oe_o(oe), .resolution_i(res), .crit_trip_i(crit), .upper_trip_i(upper),
      .lower_trip_i(lower), .event_o(ev), .low_power_select_o(lp),
      .limit_hysteresis_o(hy), .crit_lock_o(cl), .win_lock_o(wl));
   cfg_host_model cfg_host_model_i (.clk_i(clk), .sda_oe_i(oe), .scl_o(scl), .line_o(sda));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict

   // The whole sequence needs under ten thousand cycles.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic rdchk(input logic [3:0] p, input logic [15:0] e, input string n);
      cfg_host_model_i.rd(p, v);
      chk(n, e, v);
   endtask : rdchk

   task automatic setev(input logic c, input logic u, input logic l, input logic e);
      @(posedge clk) crit <= c;
      upper <= u;
      lower <= l;
      repeat (3) @(posedge clk);
      @(negedge clk) chk("event pin", {15'h0, e}, {15'h0, ev});
   endtask : setev

   initial begin
      rst_n = 1'b0;
      res = 2'b01;
      crit = 1'b0;
      upper = 1'b0;
      lower = 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rdchk(4'h1, 16'h0000, "config reset");
      rdchk(4'h0, 16'h000f, "capability");
      res <= 2'b10;
      rdchk(4'h0, 16'h0017, "capability res");
      rdchk(4'h5, 16'h0000, "unmapped");
      $display("capability test done");
      cfg_host_model_i.wr(4'h1, 16'hff2f);
      rdchk(4'h1, 16'h070f, "config all");
      chk("low power pin", 16'h0001, {15'h0, lp});
      for (int h = 0; h < 4; h++) begin
         cfg_host_model_i.wr(4'h1, {5'h00, h[1:0], 9'h000});
         chk("hysteresis", h[15:0], {14'h0, hy});
      end
      $display("field test done");
      cfg_host_model_i.wr(4'h1, 16'h0008);
      setev(1'b0, 1'b0, 1'b1, 1'b0);
      rdchk(4'h1, 16'h0018, "status on");
      setev(1'b0, 1'b0, 1'b0, 1'b1);
      cfg_host_model_i.wr(4'h1, 16'h0009);
      setev(1'b0, 1'b1, 1'b0, 1'b0);
      setev(1'b0, 1'b0, 1'b0, 1'b0);
      rdchk(4'h1, 16'h0019, "status latched");
      cfg_host_model_i.wr(4'h1, 16'h0029);
      chk("event cleared", 16'h0001, {15'h0, ev});
      cfg_host_model_i.wr(4'h1, 16'h000e);
      setev(1'b0, 1'b1, 1'b0, 1'b0);
      setev(1'b1, 1'b1, 1'b0, 1'b1);
      cfg_host_model_i.wr(4'h1, 16'h0000);
      setev(1'b1, 1'b0, 1'b0, 1'b1);
      setev(1'b0, 1'b0, 1'b0, 1'b1);
      $display("event test done");
      cfg_host_model_i.wr(4'h1, 16'h0181);
      cfg_host_model_i.wr(4'h1, 16'h068e);
      rdchk(4'h1, 16'h0085, "locked write");
      cfg_host_model_i.wr(4'h1, 16'h0040);
      rdchk(4'h1, 16'h00c1, "both locks");
      cfg_host_model_i.wr(4'h1, 16'h0104);
      rdchk(4'h1, 16'h00c1, "shutdown refused");
      chk("lock pins", 16'h0003, {14'h0, cl, wl});
      chk("acks", 16'h0000, cfg_host_model_i.nack_cnt[15:0]);
      $display("lock test done");
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rdchk(4'h1, 16'h0000, "locks after reset");
      $display("reset test done");
      print_verdict();
   end
endmodule : thermal_sensor_config_regs_tb
